// ===== design/pfo_failover.sv
// Pair failover top: mapping, alarm fill, section state and loopback.
// Assumes a core byte stream from the pairs, per-pair transceiver flags and a plain register port.
//
// Overview of operation
// - Core frame is 144 bytes per 500 us.
// - Healthy pairs keep their slot mapping unchanged.
// - Lost channel slots are filled with all-ones.
// - Alignment and signalling slots show reduced capacity.
// - Operations channel is sent on every pair.
// - Pair failure drives fill and optional reallocation.
// - All pairs are monitored, failed ones especially.
// - Restored pair may get its slots back.
// - Operational needs activation, correct identification, no failure.
// - Any bad pair makes the section non-operational.
// - Other pairs keep carrying data on failure.
// - Signal or alignment loss fills that pair's slots.
// - Loopback request loops every transceiver near line.
// - Sync word loss alone is no failure.
// - Activation flags report pair failure.
// - Failed transceiver retries start-up independently.
// - Reactivated link clears the pair failure flag.
//
// The register addresses and the address-and-strobe port were decided locally.
module pfo_failover
    import pfo_pkg::*;
#(
    parameter logic [31:0] RETRY = 32'(RETRY_CYCLES),
    parameter logic [31:0] FRAME_TIMEOUT = 32'(FRAME_TIMEOUT_CYCLES)
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Core frame bytes from the pair side.
    input wire logic core_valid,
    input wire logic core_sof,
    input wire logic [7:0] core_byte,
    // Core frame bytes toward the application interface.
    output logic app_valid,
    output logic app_sof,
    output logic [7:0] app_byte,
    // Transceiver flags, one bit per pair.
    input wire logic [NUM_PAIRS-1:0] signal_lost_flag,
    input wire logic [NUM_PAIRS-1:0] frame_align_lost_flag,
    input wire logic [NUM_PAIRS-1:0] timing_lost_flag,
    input wire logic [NUM_PAIRS-1:0] sync_word_lost_flag,
    input wire logic [NUM_PAIRS-1:0] pair_active,
    input wire logic [NUM_PAIRS-1:0] pair_id_ok,
    // Transceiver control, one bit per pair.
    output logic [NUM_PAIRS-1:0] pair_restart,
    output logic [NUM_PAIRS-1:0] pair_loopback,
    // Line-side loopback request from the application interface.
    input wire logic loop_request,
    // Operations channel toward the pairs.
    input wire logic eoc_valid,
    input wire logic [7:0] eoc_byte,
    output logic [NUM_PAIRS-1:0] pair_eoc_valid,
    output logic [7:0] pair_eoc_byte,
    // Section state and interrupt.
    output logic section_operational,
    output logic irq
);
    // Registers.
    logic [31:0] ctrl;
    logic [31:0] int_status;
    logic [31:0] int_mask;
    // Frame fill mask, restored-pair memory and last-cycle failure flags.
    logic [NUM_PAIRS-1:0] fill_mask;
    logic [NUM_PAIRS-1:0] held;
    logic [NUM_PAIRS-1:0] failed_q;
    logic oper_q;

    // Per-pair monitors.
    logic [NUM_PAIRS-1:0] failed;
    logic [NUM_PAIRS-1:0] restart;

    // Frame position.
    logic [7:0] byte_idx;
    logic frame_ok;

    // Every pair gets its own monitor, so one pair's start-up never waits on another's.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAIRS; gi = gi + 1)
        begin : g_pair
            pfo_pair_mon #(
                .RETRY(RETRY)
            ) u_mon (
                .clk(clk),
                .rst(rst),
                .sig_lost(signal_lost_flag[gi]),
                .align_lost(frame_align_lost_flag[gi]),
                .timing_lost(timing_lost_flag[gi]),
                .active(pair_active[gi]),
                .failed(failed[gi]),
                .restart(restart[gi])
            );
        end
    endgenerate

    // Byte position within the core frame.
    pfo_frame_ctr #(
        .TIMEOUT(FRAME_TIMEOUT)
    ) u_frame (
        .clk(clk),
        .rst(rst),
        .valid(core_valid),
        .sof(core_sof),
        .byte_idx(byte_idx),
        .frame_ok(frame_ok)
    );

    // Register decode.
    wire sel_ctrl = (reg_addr == REG_CTRL);
    wire sel_status = (reg_addr == REG_STATUS);
    wire sel_int_status = (reg_addr == REG_INT_STATUS);
    wire sel_int_mask = (reg_addr == REG_INT_MASK);
    wire sel_fill = (reg_addr == REG_FILL);
    wire wr_ctrl = reg_wr & sel_ctrl;
    wire wr_int_status = reg_wr & sel_int_status;
    wire wr_int_mask = reg_wr & sel_int_mask;

    // Control fields in use.
    wire fill_en = ctrl[CTRL_FILL_EN_BIT];
    wire sw_loop = ctrl[CTRL_LOOP_BIT];
    wire realloc_en = ctrl[CTRL_REALLOC_BIT];

    // Operational only with every pair activated, identified and free of failure.
    // Sync word loss is left out on purpose: a noise burst must not take the section down.
    wire all_active = &pair_active;
    wire all_id_ok = &pair_id_ok;
    wire any_failed = |failed;
    wire next_oper = all_active & all_id_ok & ~any_failed & frame_ok;

    // Line-side loopback, asked for by the application interface or software.
    wire loop_on = loop_request | sw_loop;

    // Fill for the next frame: with fill enabled a failed pair is always filled; a restored pair stays
    // filled until reallocation is allowed, so software decides when capacity comes back.
    wire [NUM_PAIRS-1:0] want_fill = fill_en ? (failed | (held & ~{NUM_PAIRS{realloc_en}})) :
        {NUM_PAIRS{1'b0}};

    // Frame boundary: the first byte of a new frame.
    wire frame_start = core_valid & (byte_idx == 8'h00);

    // The fill mask changes only at the frame start so no frame mixes data and alarm fill.
    wire [NUM_PAIRS-1:0] active_mask = frame_start ? want_fill : fill_mask;
    wire partial = |active_mask;

    // Byte classification.
    wire in_fas = (byte_idx >= FAS_FIRST_IDX) & (byte_idx <= FAS_LAST_IDX);
    wire in_sig = (byte_idx >= SIG_FIRST_IDX) & (byte_idx <= SIG_LAST_IDX);
    wire shared_slot = in_fas | in_sig;
    wire [1:0] owner = pfo_byte_owner(byte_idx);
    wire owner_lost = active_mask[owner];

    // Output byte: data slots of lost pairs become all-ones, others pass; shared
    // slots carry a reduced-capacity indication while any pair is filled.
    wire [7:0] shared_bits = in_fas ? FAS_PARTIAL_BITS : SIG_PARTIAL_BITS;
    wire [7:0] shared_byte = partial ? (core_byte | shared_bits) : core_byte;
    wire [7:0] data_byte = owner_lost ? ALL_ONES_BYTE : core_byte;
    wire [7:0] next_app_byte = shared_slot ? shared_byte : data_byte;

    // Interrupt events: new failure, restoration, change of section state.
    wire [NUM_PAIRS-1:0] ev_fail = failed & ~failed_q;
    wire [NUM_PAIRS-1:0] ev_restore = ~failed & failed_q;
    wire ev_oper = next_oper ^ oper_q;
    wire [31:0] events = (32'(ev_fail) << INT_FAIL_LSB) | (32'(ev_restore) << INT_RESTORE_LSB) |
        (32'(ev_oper) << INT_OPER_BIT);
    wire [31:0] int_clear = wr_int_status ? reg_wdata : 32'h0000_0000;
    // A new event beats a clear written in the same cycle.
    wire [31:0] next_int_status = (int_status & ~int_clear) | events;

    // Status word.
    wire [31:0] status_word = (32'(oper_q) << STAT_OPER_BIT) | (32'(frame_ok) << STAT_FRAME_OK_BIT) |
        (32'(loop_on) << STAT_LOOP_BIT) | (32'(failed) << STAT_FAIL_LSB) |
        (32'(sync_word_lost_flag) << STAT_SYNCW_LSB) | (32'(pair_id_ok) << STAT_ID_LSB);

    // Read data select; unmapped addresses read as zero.
    wire [31:0] next_rdata = sel_ctrl ? ctrl :
        sel_status ? status_word :
        sel_int_status ? int_status :
        sel_int_mask ? int_mask :
        sel_fill ? 32'(fill_mask) : 32'h0000_0000;

    // Control register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= reg_wdata;
    end

    // Interrupt status and mask.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            int_status <= 32'h0000_0000;
            int_mask <= INT_MASK_RESET;
        end
        else
        begin
            int_status <= next_int_status;
            if (wr_int_mask)
                int_mask <= reg_wdata;
        end
    end

    // Read data stands for one cycle after the read strobe only.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h0000_0000;
    end

    // Pairs that failed and have not yet got their slots back.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            held <= {NUM_PAIRS{1'b0}};
        else if (realloc_en)
            held <= failed;
        else
            held <= held | failed;
    end

    // Frame-locked fill mask.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fill_mask <= {NUM_PAIRS{1'b0}};
        else if (frame_start)
            fill_mask <= want_fill;
    end

    // Edge memories for the events.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            failed_q <= {NUM_PAIRS{1'b1}};
            oper_q <= 1'b0;
        end
        else
        begin
            failed_q <= failed;
            oper_q <= next_oper;
        end
    end

    // Data path toward the application, one register stage.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            app_valid <= 1'b0;
            app_sof <= 1'b0;
            app_byte <= 8'h00;
        end
        else
        begin
            app_valid <= core_valid;
            app_sof <= frame_start;
            app_byte <= core_valid ? next_app_byte : 8'h00;
        end
    end

    // The operations channel goes out on every pair so it survives a single failure.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pair_eoc_valid <= {NUM_PAIRS{1'b0}};
            pair_eoc_byte <= 8'h00;
        end
        else
        begin
            pair_eoc_valid <= {NUM_PAIRS{eoc_valid}};
            pair_eoc_byte <= eoc_byte;
        end
    end

    // Transceiver control and section state.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pair_restart <= {NUM_PAIRS{1'b0}};
            pair_loopback <= {NUM_PAIRS{1'b0}};
            section_operational <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pair_restart <= restart;
            pair_loopback <= {NUM_PAIRS{loop_on}};
            section_operational <= next_oper;
            irq <= |(next_int_status & int_mask);
        end
    end
endmodule // pfo_failover

// ===== design/pfo_pkg.sv
// Package for the pair failover block: sizes, timing, register map and fields.
// Assumes a single 10 MHz core clock and a three pair system with the 144 byte core frame.
package pfo_pkg;

    // System size.
    localparam int NUM_PAIRS = 3;
    localparam int FRAME_BYTES = 144;
    localparam logic [7:0] LAST_BYTE_IDX = 8'h8F;

    // Time base: the core frame lasts 500 us at a 10 MHz clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int FRAME_TIME_US = 500;
    localparam int FRAME_CYCLES = (FRAME_TIME_US * 1000) / CLK_PERIOD_NS;
    // A frame start is missing after two frame periods.
    localparam int FRAME_TIMEOUT_CYCLES = 2 * FRAME_CYCLES;
    // Pause between two start-up attempts of a failed transceiver.
    localparam int RETRY_TIME_US = 100000;
    localparam int RETRY_CYCLES = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;

    // Shared slots: frame alignment bytes and signalling bytes of the core frame.
    localparam logic [7:0] FAS_FIRST_IDX = 8'h00;
    localparam logic [7:0] FAS_LAST_IDX = 8'h02;
    localparam logic [7:0] SIG_FIRST_IDX = 8'h12;
    localparam logic [7:0] SIG_LAST_IDX = 8'h14;
    // Bits forced in shared slots while capacity is reduced.
    localparam logic [7:0] FAS_PARTIAL_BITS = 8'h20;
    localparam logic [7:0] SIG_PARTIAL_BITS = 8'h04;
    localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    localparam logic [7:0] REG_FILL = 8'h10;

    // Control fields.
    localparam int CTRL_FILL_EN_BIT = 0;
    localparam int CTRL_LOOP_BIT = 1;
    localparam int CTRL_REALLOC_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0005;

    // Status fields.
    localparam int STAT_OPER_BIT = 0;
    localparam int STAT_FRAME_OK_BIT = 1;
    localparam int STAT_LOOP_BIT = 2;
    localparam int STAT_FAIL_LSB = 4;
    localparam int STAT_SYNCW_LSB = 8;
    localparam int STAT_ID_LSB = 12;

    // Interrupt fields, shared by status and mask.
    localparam int INT_FAIL_LSB = 0;
    localparam int INT_RESTORE_LSB = 4;
    localparam int INT_OPER_BIT = 8;
    localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;

    // Owner of a data byte: pairs carry consecutive bytes in turn.
    function automatic logic [1:0] pfo_byte_owner(input logic [7:0] idx);
        logic [7:0] rem;
        rem = idx % 8'd3;
        return rem[1:0];
    endfunction

endpackage

// ===== design/pfo_pair_mon.sv
// One pair's failure monitor and autonomous start-up retry.
// Assumes transceiver flags are synchronous to clk and high while the fault lasts.
module pfo_pair_mon
    import pfo_pkg::*;
#(
    parameter logic [31:0] RETRY = 32'(RETRY_CYCLES)
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Transceiver activation flags.
    input wire logic sig_lost,
    input wire logic align_lost,
    input wire logic timing_lost,
    input wire logic active,
    // Monitor results.
    output logic failed,
    output logic restart
);
    logic [31:0] retry_cnt;
    wire fault_now = sig_lost | align_lost | timing_lost | ~active;
    wire link_back = active & ~sig_lost & ~align_lost & ~timing_lost;
    wire retry_due = failed & ~link_back & (retry_cnt == 32'h0000_0000);

    // The failure flag holds until the link is truly back.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            failed <= 1'b1;
        else if (fault_now)
            failed <= 1'b1;
        else if (link_back)
            failed <= 1'b0;
    end

    // Start-up is retried on this pair alone until the link returns.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            retry_cnt <= 32'h0000_0000;
            restart <= 1'b0;
        end
        else
        begin
            restart <= retry_due;
            if (~failed | link_back)
                retry_cnt <= 32'h0000_0000;
            else if (retry_due)
                retry_cnt <= RETRY - 32'h0000_0001;
            else
                retry_cnt <= retry_cnt - 32'h0000_0001;
        end
    end
endmodule // pfo_pair_mon

// ===== design/pfo_frame_ctr.sv
// Core frame byte counter and frame-start watchdog.
// Assumes the source marks the first byte of every core frame with sof beside valid.
module pfo_frame_ctr
    import pfo_pkg::*;
#(
    parameter logic [31:0] TIMEOUT = 32'(FRAME_TIMEOUT_CYCLES)
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Incoming byte strobes.
    input wire logic valid,
    input wire logic sof,
    // Position in frame.
    output logic [7:0] byte_idx,
    output logic frame_ok
);
    logic [31:0] since_sof;
    logic [7:0] cnt;
    wire start = valid & sof;

    // Index of the byte now on the input; sof forces it to zero.
    assign byte_idx = sof ? 8'h00 : cnt;

    // Counts bytes; the 144 byte frame wraps by itself if sof is late.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= 8'h00;
        else if (valid)
            cnt <= (byte_idx == LAST_BYTE_IDX) ? 8'h00 : byte_idx + 8'h01;
    end

    // Watchdog: frame alignment is good only while starts keep arriving.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            since_sof <= 32'h0000_0000;
            frame_ok <= 1'b0;
        end
        else if (start)
        begin
            since_sof <= 32'h0000_0000;
            frame_ok <= 1'b1;
        end
        else if (since_sof >= TIMEOUT)
            frame_ok <= 1'b0;
        else
            since_sof <= since_sof + 32'h0000_0001;
    end
endmodule // pfo_frame_ctr

// ===== verification/pfo_failover_sva.sv
// Checker for the pair failover top: relations between its ports.
// Assumes it is bound to pfo_failover and sees that module's ports only.
module pfo_failover_sva
    import pfo_pkg::*;
#(
    parameter logic [31:0] RETRY = 32'(RETRY_CYCLES)
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Frame path.
    input wire logic core_valid,
    input wire logic core_sof,
    input wire logic app_valid,
    input wire logic app_sof,
    // Pair side.
    input wire logic [NUM_PAIRS-1:0] signal_lost_flag,
    input wire logic [NUM_PAIRS-1:0] frame_align_lost_flag,
    input wire logic [NUM_PAIRS-1:0] timing_lost_flag,
    input wire logic [NUM_PAIRS-1:0] pair_active,
    input wire logic [NUM_PAIRS-1:0] pair_id_ok,
    input wire logic [NUM_PAIRS-1:0] pair_restart,
    input wire logic [NUM_PAIRS-1:0] pair_loopback,
    input wire logic loop_request,
    // Operations channel and state.
    input wire logic eoc_valid,
    input wire logic [7:0] eoc_byte,
    input wire logic [NUM_PAIRS-1:0] pair_eoc_valid,
    input wire logic [7:0] pair_eoc_byte,
    input wire logic section_operational
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gap;
    wire logic link_bad = |(signal_lost_flag | frame_align_lost_flag | timing_lost_flag | ~pair_active);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles since pair 1 last asked for start-up while its line is cut.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || pair_restart[1] || !signal_lost_flag[1])
            gap <= '0;
        else
            gap <= gap + 32'd1;
    end

    // Latency limits of the outputs.
    a_data_latency: assert property (core_valid |=> app_valid)
        else $error("no app byte");
    a_sof_follow: assert property (core_valid && core_sof |=> app_sof)
        else $error("no app sof");
    a_eoc_parallel: assert property (eoc_valid |=> &pair_eoc_valid && pair_eoc_byte == $past(eoc_byte))
        else $error("eoc not copied");
    a_loop_all: assert property (loop_request |=> &pair_loopback)
        else $error("loop not all");
    a_loss_down: assert property ((|signal_lost_flag)[*4] |-> !section_operational)
        else $error("up with lost signal");
    a_badid_down: assert property ((!(&pair_id_ok))[*4] |-> !section_operational)
        else $error("up with bad id");
    a_inactive_down: assert property ((!(&pair_active))[*4] |-> !section_operational)
        else $error("up before activation");
    a_no_restart: assert property ((!link_bad)[*4] |-> pair_restart == '0)
        else $error("restart when healthy");
    a_retry_bound: assert property (gap < RETRY + 32'd8)
        else $error("retries stopped");

    c_oper: cover property ($rose(section_operational));
    c_restart: cover property (|pair_restart);
    c_loop: cover property (loop_request ##1 &pair_loopback);
endmodule // pfo_failover_sva

// ===== verification/pfo_line_model.sv
// Behavioural pair side: three transceivers and a back to back core frame source.
// Assumes the bench steers faults through the control inputs after a rising edge.
module pfo_line_model
    import pfo_pkg::*;
#(
    parameter int WAKE = 5
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Fault controls from the bench.
    input wire logic [NUM_PAIRS-1:0] cut,
    input wire logic [NUM_PAIRS-1:0] misalign,
    input wire logic [NUM_PAIRS-1:0] bad_id,
    input wire logic [NUM_PAIRS-1:0] noisy,
    input wire logic [NUM_PAIRS-1:0] pair_restart,
    // Toward the block.
    output logic core_valid,
    output logic core_sof,
    output logic [7:0] core_byte,
    output logic [NUM_PAIRS-1:0] signal_lost_flag,
    output logic [NUM_PAIRS-1:0] frame_align_lost_flag,
    output logic [NUM_PAIRS-1:0] timing_lost_flag,
    output logic [NUM_PAIRS-1:0] sync_word_lost_flag,
    output logic [NUM_PAIRS-1:0] pair_active,
    output logic [NUM_PAIRS-1:0] pair_id_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idx;
    int wake_cnt [NUM_PAIRS];

    // Each byte carries its own index, so any slip or fill shows at once.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            idx <= 8'h00;
        else
            idx <= (idx == LAST_BYTE_IDX) ? 8'h00 : idx + 8'h01;
    end
    assign core_valid = !rst;
    assign core_sof = !rst && idx == 8'h00;
    assign core_byte = idx;

    // Flags follow the faults; a cut line drops both signal and timing.
    assign signal_lost_flag = cut;
    assign timing_lost_flag = cut;
    assign frame_align_lost_flag = misalign;
    assign sync_word_lost_flag = noisy;
    assign pair_id_ok = ~bad_id;

    // A pair returns only after a start-up request on a healed line.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pair_active <= '1;
            wake_cnt <= '{default: 0};
        end
        else
            for (int i = 0; i < NUM_PAIRS; i++)
            begin
                if (cut[i])
                begin
                    pair_active[i] <= 1'b0;
                    wake_cnt[i] <= 0;
                end
                else if (wake_cnt[i] != 0)
                begin
                    wake_cnt[i] <= wake_cnt[i] - 1;
                    pair_active[i] <= (wake_cnt[i] == 1);
                end
                else if (pair_restart[i] && !pair_active[i])
                    wake_cnt[i] <= WAKE;
            end
    end
endmodule // pfo_line_model

// ===== verification/pfo_failover_bench.sv
// Self-checking bench for the pair failover block against the line model.
// Assumes package, design, line model and checker are compiled first.
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) \
    begin fails++; $display("Error at %0t: %s", $time, msg); end end
module pfo_failover_bench
    import pfo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, eoc_byte = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, loop_request = 1'b0, eoc_valid = 1'b0;
    logic [NUM_PAIRS-1:0] cut = '0, misalign = '0, bad_id = '0, noisy = '0;
    logic [31:0] reg_rdata, rd_val;
    logic core_valid, core_sof, app_valid, app_sof, section_operational, irq;
    logic [7:0] core_byte, app_byte, pair_eoc_byte;
    logic [NUM_PAIRS-1:0] signal_lost_flag, frame_align_lost_flag, timing_lost_flag, sync_word_lost_flag;
    logic [NUM_PAIRS-1:0] pair_active, pair_id_ok, pair_restart, pair_loopback, pair_eoc_valid;
    int fails = 0, checks_done = 0;

    // Short retry and watchdog counts keep the run brief.
    always #50 clk = ~clk;
    pfo_failover #(.RETRY(32'd20), .FRAME_TIMEOUT(32'd400)) u_pfo_failover (.clk, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .core_valid, .core_sof, .core_byte, .app_valid, .app_sof, .app_byte,
        .signal_lost_flag, .frame_align_lost_flag, .timing_lost_flag, .sync_word_lost_flag, .pair_active,
        .pair_id_ok, .pair_restart, .pair_loopback, .loop_request, .eoc_valid, .eoc_byte, .pair_eoc_valid,
        .pair_eoc_byte, .section_operational, .irq);
    pfo_line_model u_pfo_line_model (.clk, .rst, .cut, .misalign, .bad_id, .noisy, .pair_restart, .core_valid,
        .core_sof, .core_byte, .signal_lost_flag, .frame_align_lost_flag, .timing_lost_flag,
        .sync_word_lost_flag, .pair_active, .pair_id_ok);

    // Register port: one-cycle strobes, read data one cycle later.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wait_oper(input logic exp);
        int n = 0;
        while (section_operational !== exp && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(section_operational, exp, "section state")
        if (n == 2000)
            conclude();
        @(posedge clk);
    endtask

    // Compares one output frame; the index pattern makes every byte predictable.
    task automatic check_frame(input logic [NUM_PAIRS-1:0] mask);
        logic [7:0] exp;
        int n = 0;
        repeat (2) @(negedge clk);
        while (app_sof !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(app_sof, 1'b1, "no frame start")
        if (n == 400)
            conclude();
        for (int i = 0; i < FRAME_BYTES; i++)
        begin
            if (i <= 2)
                exp = 8'(i) | (mask != 0 ? FAS_PARTIAL_BITS : 8'h00);
            else if (i >= 18 && i <= 20)
                exp = 8'(i) | (mask != 0 ? SIG_PARTIAL_BITS : 8'h00);
            else
                exp = mask[i % 3] ? ALL_ONES_BYTE : 8'(i);
            `CHK(app_byte, exp, "mapped byte")
            @(negedge clk);
        end
        @(posedge clk);
    endtask

    // Main sequence; each fault is cleared before the next.
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CTRL);
        `CHK(rd_val, CTRL_RESET, "ctrl reset")
        rd(8'h20);
        `CHK(rd_val, 32'h0000_0000, "unmapped read")
        wait_oper(1'b1);
        wr(REG_INT_STATUS, 32'h0000_01FF);
        check_frame(3'b000);
        noisy <= 3'b111;
        check_frame(3'b000);
        rd(REG_STATUS);
        `CHK(rd_val[10:8], 3'b111, "sync status")
        `CHK(section_operational, 1'b1, "noise fault")
        noisy <= 3'b000;
        wr(REG_INT_MASK, 32'h0000_0002);
        cut <= 3'b010;
        wait_oper(1'b0);
        check_frame(3'b010);
        rd(REG_STATUS);
        `CHK(rd_val[6:4], 3'b010, "failed pairs")
        rd(REG_INT_STATUS);
        `CHK(rd_val, 32'h0000_0102, "fail events")
        `CHK(irq, 1'b1, "irq set")
        wr(REG_INT_STATUS, 32'h0000_0102);
        cut <= 3'b000;
        #1 `CHK(irq, 1'b0, "irq clear")
        wait_oper(1'b1);
        check_frame(3'b000);
        rd(REG_INT_STATUS);
        `CHK(rd_val[6:4], 3'b010, "restore event")
        wr(REG_CTRL, 32'h0000_0001);
        misalign <= 3'b001;
        wait_oper(1'b0);
        check_frame(3'b001);
        misalign <= 3'b000;
        wait_oper(1'b1);
        check_frame(3'b001);
        wr(REG_CTRL, CTRL_RESET);
        check_frame(3'b000);
        bad_id <= 3'b100;
        wait_oper(1'b0);
        bad_id <= 3'b000;
        wait_oper(1'b1);
        @(posedge clk);
        loop_request <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(pair_loopback, 3'b111, "loopback")
        loop_request <= 1'b0;
        wr(REG_CTRL, 32'h0000_0007);
        rd(REG_STATUS);
        `CHK(rd_val[2], 1'b1, "loop status")
        `CHK(pair_loopback, 3'b111, "sw loopback")
        wr(REG_CTRL, CTRL_RESET);
        eoc_byte <= 8'hA5;
        eoc_valid <= 1'b1;
        @(posedge clk);
        eoc_valid <= 1'b0;
        @(negedge clk);
        `CHK(pair_eoc_valid, 3'b111, "eoc valid")
        `CHK(pair_eoc_byte, 8'hA5, "eoc byte")
        conclude();
    end
endmodule // pfo_failover_bench

bind pfo_failover pfo_failover_sva #(.RETRY(RETRY)) u_pfo_failover_sva (.clk, .rst, .core_valid, .core_sof,
    .app_valid, .app_sof, .signal_lost_flag, .frame_align_lost_flag, .timing_lost_flag, .pair_active,
    .pair_id_ok, .pair_restart, .pair_loopback, .loop_request, .eoc_valid, .eoc_byte, .pair_eoc_valid,
    .pair_eoc_byte, .section_operational);
